/* rtl/timer_pwm_unit.v */
`timescale 1ns/1ps
// Function
// - Clock source field: 00 off, 01 bus clock, 10 unused, 11 crystal clock.
// - Crystal selection counts from the 500 kHz crystal-derived clock.
// - Selected clock passes a prescaler dividing by 1 to 128.
// - One 16-bit counter, time base for capture, compare and edge PWM.
// - Counter limit comes from the 16-bit modulo value, high and low bytes.
// - Modulo 0x0000 or 0xFFFF gives a free-running full-range counter.
// - Counter reads never disturb counting.
// - Any write to either counter byte resets the counter.
// - Center-aligned mode counts up/down and applies to all channels.
// - Each channel is capture, compare or edge-aligned PWM independently.
// - Capture triggers on rising, falling or either edge.
// - Compare match sets, clears or toggles the pin.
// - PWM output polarity is selectable.
// - One interrupt per channel plus one overflow interrupt.
// - System option bit routes channel 0 from pin or low-freq oscillator.
// - Channels drive two shared port pins when enabled.
// - Overflow flag sets on wrap to zero, or stepping down from modulo.
// - Flag clears by read while set then write 0; new event restarts.
// - Overflow interrupt while enable and flag; reset clears both.
// - Prescale codes 000 to 111 map to divide 1 up to 128.
module timer_pwm_unit #(
  parameter CW = 16
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire crystal_derived_clock_i,
  input wire low_freq_oscillator_i,
  input wire [1:0] pin_i,
  output reg [1:0] pin_o,
  output wire [1:0] pin_oe_o,
  output wire [1:0] ch_irq_o,
  output wire ovf_irq_o
);
`include "timer_pwm_unit_defines.vh"

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] sc;
  reg [CW-1:0] count_value;
  reg [CW-1:0] modulo_value;
  reg [7:0] mod_hi_buf;
  reg [7:0] cc [0:1];
  wire [CW-1:0] cv [0:1];
  wire [CW-1:0] cv_act [0:1];
  wire [1:0] ch_level;
  reg [7:0] cv_hi_buf [0:1];
  reg channel0_osc_route;
  reg ovf_armed;
  reg [1:0] ch_armed;
  reg down;
  reg [7:0] cnt_lo_latch;
  reg [1:0] dx_sync;
  reg dx_prev;
  reg [6:0] pre;
  reg [1:0] in_prev;

  wire [1:0] clk_sel = sc[`SC_CLK_HI:`SC_CLK_LO];
  wire [2:0] prescale_select = sc[`SC_PS_HI:0];
  wire center_aligned_pwm = sc[`SC_CENTER];
  wire overflow_flag = sc[`SC_OVF];
  wire overflow_irq_enable = sc[`SC_OVIE];

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  // The crystal clock is sampled by two flops and its rising edge is taken from
  // the synchronised copy only, so it must stay well below half the bus rate.
  wire dx_edge = dx_sync[1] & ~dx_prev;
  wire src_tick = (clk_sel == `CLK_BUS) ? 1'b1 :
                  (clk_sel == `CLK_XTAL) ? dx_edge : 1'b0;
  wire [6:0] pre_mask = (7'h01 << prescale_select) - 7'h01;
  wire tick = src_tick & ((pre & pre_mask) == pre_mask);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  wire free_run = (modulo_value == `CNT_ZERO) || (modulo_value == `CNT_FULL);
  wire [CW-1:0] top = free_run ? `CNT_FULL : modulo_value;
  wire up_wrap = tick & ~center_aligned_pwm & (count_value == top);
  wire cw_turn = tick & center_aligned_pwm & ~down & (count_value == top);
  wire ovf_event = up_wrap | cw_turn;
  wire period_start = up_wrap | (tick & center_aligned_pwm & down &
                      (count_value == `CNT_ZERO + 16'h0001));
  wire cnt_write = wr_i & ((addr_i == `OFS_CNT_HI) || (addr_i == `OFS_CNT_LO));
  wire sc_write = wr_i & (addr_i == `OFS_STAT_CTRL);

  reg [CW-1:0] next_count;
  reg next_down;
  always @* begin
    next_count = count_value;
    next_down = down;
    if (cnt_write) begin
      next_count = `CNT_ZERO;
      next_down = 1'b0;
    end else if (tick) begin
      if (!center_aligned_pwm) begin
        next_count = (count_value == top) ? `CNT_ZERO : count_value + 16'h0001;
        next_down = 1'b0;
      end else if (!down) begin
        if (count_value == top) begin
          next_count = count_value - 16'h0001;
          next_down = 1'b1;
        end else begin
          next_count = count_value + 16'h0001;
        end
      end else begin
        if (count_value == `CNT_ZERO + 16'h0001) begin
          next_down = 1'b0;
        end
        next_count = count_value - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  wire [1:0] ch_in;
  assign ch_in[0] = channel0_osc_route ? low_freq_oscillator_i : pin_i[0];
  assign ch_in[1] = pin_i[1];
  wire [1:0] ch_event;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire [1:0] mode = cc[g][`CC_MODE_HI:`CC_MODE_LO];
      wire [1:0] els = cc[g][`CC_ELS_HI:`CC_ELS_LO];
      wire rise = ch_in[g] & ~in_prev[g];
      wire fall = ~ch_in[g] & in_prev[g];
      wire capt = ~center_aligned_pwm && (mode == `MODE_CAPT) &&
                  ((els[0] & rise) | (els[1] & fall));
      wire match = tick && (count_value == cv_act[g]);
      wire cmp = ~center_aligned_pwm && (mode == `MODE_CMP) && match;
      wire pwm = center_aligned_pwm || mode[1];
      // Each channel owns its flops, so every register has a single driving process.
      reg level;
      reg [CW-1:0] value;
      reg [CW-1:0] value_act;
      assign cv[g] = value;
      assign cv_act[g] = value_act;
      assign ch_level[g] = level;
      assign ch_event[g] = capt | cmp | (pwm & match);
      assign pin_oe_o[g] = (els != 2'h0) && (pwm || (mode == `MODE_CMP));
      assign ch_irq_o[g] = cc[g][`CC_FLAG] & cc[g][`CC_IE];
      always @(posedge mclk_i) begin
        if (rst_i) begin
          level <= 1'b0;
          value <= `CNT_ZERO;
          value_act <= `CNT_ZERO;
        end else begin
          if (capt) begin
            value <= count_value;
          end else if (wr_i && addr_i == `OFS_CH0_VAL_LO + g * 3) begin
            value <= {cv_hi_buf[g], wdata_i};
          end
          // Edge and center PWM duty values are taken at the period boundary,
          // which keeps a half-written value from producing a runt pulse.
          if (!pwm || period_start) begin
            value_act <= value;
          end
          if (cmp) begin
            case (els)
              2'h1: level <= ~level;
              2'h2: level <= 1'b0;
              2'h3: level <= 1'b1;
              default: level <= level;
            endcase
          end else if (pwm) begin
            if (period_start) begin
              level <= ~els[0];
            end else if (match) begin
              level <= els[0];
            end
          end
        end
      end
    end
  endgenerate

  assign ovf_irq_o = overflow_flag & overflow_irq_enable;

  // The pin levels live in the channel flops; this only gathers them,
  // so every register still has exactly one process driving it.
  always @* begin
    pin_o = ch_level;
  end

  // ----------------------------------------
  // Sequential state and register writes
  // ----------------------------------------
  integer i;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sc <= `BYTE_ZERO;
      count_value <= `CNT_ZERO;
      modulo_value <= `CNT_ZERO;
      mod_hi_buf <= `BYTE_ZERO;
      channel0_osc_route <= 1'b0;
      ovf_armed <= 1'b0;
      ch_armed <= 2'h0;
      down <= 1'b0;
      cnt_lo_latch <= `BYTE_ZERO;
      dx_sync <= 2'h0;
      dx_prev <= 1'b0;
      pre <= 7'h00;
      in_prev <= 2'h0;
      for (i = 0; i < 2; i = i + 1) begin
        cc[i] <= `BYTE_ZERO;
        cv_hi_buf[i] <= `BYTE_ZERO;
      end
    end else begin
      dx_sync <= {dx_sync[0], crystal_derived_clock_i};
      dx_prev <= dx_sync[1];
      in_prev <= ch_in;
      // The prescaler restarts while the timer is stopped, so the first divided
      // tick comes a full ratio after a clock source is chosen.
      if (clk_sel == `CLK_OFF || clk_sel == `CLK_SPARE) begin
        pre <= 7'h00;
      end else if (src_tick) begin
        pre <= pre + 7'h01;
      end
      count_value <= next_count;
      down <= next_down;
      // Counter reads only snapshot the low byte; the counter is untouched.
      if (rd_i && addr_i == `OFS_CNT_HI) begin
        cnt_lo_latch <= count_value[7:0];
      end
      if (sc_write) begin
        sc[6:0] <= wdata_i[6:0];
      end
      // An event in the clearing cycle wins and drops the pending read arm.
      if (ovf_event) begin
        sc[`SC_OVF] <= 1'b1;
        ovf_armed <= 1'b0;
      end else if (sc_write && !wdata_i[`SC_OVF] && ovf_armed) begin
        sc[`SC_OVF] <= 1'b0;
        ovf_armed <= 1'b0;
      end else if (rd_i && addr_i == `OFS_STAT_CTRL && overflow_flag) begin
        ovf_armed <= 1'b1;
      end
      if (wr_i && addr_i == `OFS_MOD_HI) begin
        mod_hi_buf <= wdata_i;
      end
      if (wr_i && addr_i == `OFS_MOD_LO) begin
        modulo_value <= {mod_hi_buf, wdata_i};
      end
      if (wr_i && addr_i == `OFS_SYS_OPT) begin
        channel0_osc_route <= wdata_i[0];
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (wr_i && addr_i == `OFS_CH0_CTRL + i * 3) begin
          cc[i][6:0] <= wdata_i[6:0];
        end
        if (wr_i && addr_i == `OFS_CH0_VAL_HI + i * 3) begin
          cv_hi_buf[i] <= wdata_i;
        end
        if (ch_event[i]) begin
          cc[i][`CC_FLAG] <= 1'b1;
          ch_armed[i] <= 1'b0;
        end else if (wr_i && addr_i == `OFS_CH0_CTRL + i * 3 &&
                     !wdata_i[`CC_FLAG] && ch_armed[i]) begin
          cc[i][`CC_FLAG] <= 1'b0;
          ch_armed[i] <= 1'b0;
        end else if (rd_i && addr_i == `OFS_CH0_CTRL + i * 3 && cc[i][`CC_FLAG]) begin
          ch_armed[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Read data, valid in the cycle after the strobe
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= `BYTE_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_STAT_CTRL: rdata_o <= sc;
        `OFS_CNT_HI: rdata_o <= count_value[15:8];
        `OFS_CNT_LO: rdata_o <= cnt_lo_latch;
        `OFS_MOD_HI: rdata_o <= modulo_value[15:8];
        `OFS_MOD_LO: rdata_o <= modulo_value[7:0];
        `OFS_CH0_CTRL: rdata_o <= cc[0];
        `OFS_CH0_VAL_HI: rdata_o <= cv[0][15:8];
        `OFS_CH0_VAL_LO: rdata_o <= cv[0][7:0];
        `OFS_CH1_CTRL: rdata_o <= cc[1];
        `OFS_CH1_VAL_HI: rdata_o <= cv[1][15:8];
        `OFS_CH1_VAL_LO: rdata_o <= cv[1][7:0];
        `OFS_SYS_OPT: rdata_o <= {7'h00, channel0_osc_route};
        default: rdata_o <= `BYTE_ZERO;
      endcase
    end else begin
      rdata_o <= `BYTE_ZERO;
    end
  end

endmodule

/* rtl/timer_pwm_unit_defines.vh */
`ifndef TIMER_PWM_UNIT_DEFINES_VH
`define TIMER_PWM_UNIT_DEFINES_VH

// ----------------------------------------
// Register offsets (byte registers)
// ----------------------------------------
`define OFS_STAT_CTRL 4'h0
`define OFS_CNT_HI 4'h1
`define OFS_CNT_LO 4'h2
`define OFS_MOD_HI 4'h3
`define OFS_MOD_LO 4'h4
`define OFS_CH0_CTRL 4'h5
`define OFS_CH0_VAL_HI 4'h6
`define OFS_CH0_VAL_LO 4'h7
`define OFS_CH1_CTRL 4'h8
`define OFS_CH1_VAL_HI 4'h9
`define OFS_CH1_VAL_LO 4'ha
`define OFS_SYS_OPT 4'hb

// ----------------------------------------
// Status/control bit positions
// ----------------------------------------
`define SC_OVF 7
`define SC_OVIE 6
`define SC_CENTER 5
`define SC_CLK_HI 4
`define SC_CLK_LO 3
`define SC_PS_HI 2

// ----------------------------------------
// Channel control bit positions
// ----------------------------------------
`define CC_FLAG 7
`define CC_IE 6
`define CC_MODE_HI 5
`define CC_MODE_LO 4
`define CC_ELS_HI 3
`define CC_ELS_LO 2

// ----------------------------------------
// Encodings
// ----------------------------------------
`define CLK_OFF 2'h0
`define CLK_BUS 2'h1
`define CLK_SPARE 2'h2
`define CLK_XTAL 2'h3
`define MODE_CAPT 2'h0
`define MODE_CMP 2'h1
`define CNT_ZERO 16'h0000
`define CNT_FULL 16'hffff
`define BYTE_ZERO 8'h00

`endif

/* test/pin_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Far side of the two shared channel pins.
// ----------------------------------------
module pin_partner (
  input wire [1:0] tmr_out_i,
  input wire [1:0] tmr_oe_i,
  input wire [1:0] ext_i,
  output wire [1:0] wire_o
);
  // An owned pin reads back the timer's level, so no party fights it.
  assign wire_o = (tmr_oe_i & tmr_out_i) | (~tmr_oe_i & ext_i);
endmodule

/* test/timer_pwm_unit_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port-level properties of the timer.
// ----------------------------------------
module timer_pwm_unit_chk (
  input wire mclk_i,
  input wire rst_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [1:0] pin_o,
  input wire [1:0] pin_oe_o,
  input wire [1:0] ch_irq_o,
  input wire ovf_irq_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr(a);
    wr_i && addr_i == a;
  endsequence
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    rdata_o == 8'h00 && pin_o == 2'b00 && pin_oe_o == 2'b00 && ch_irq_o == 2'b00 && !ovf_irq_o)
    else $error("outputs active after reset");
  a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without a read");
  a_unmapped_zero: assert property (rd_i && addr_i > 4'hb |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_count_cleared: assert property (s_wr(4'h1) ##1 s_rd(4'h1) |=> rdata_o == 8'h00)
    else $error("counter not cleared by write");
  a_ovf_flag_seen: assert property (rd_i && addr_i == 4'h0 && ovf_irq_o |=>
    rdata_o[7:6] == 2'b11) else $error("overflow request without flag");
  a_ch_flag_seen: assert property (rd_i && addr_i == 4'h5 && ch_irq_o[0] |=>
    rdata_o[7:6] == 2'b11) else $error("channel request without flag");
  a_ovf_masked: assert property (wr_i && addr_i == 4'h0 && !wdata_i[6] |=> !ovf_irq_o)
    else $error("overflow request while masked");
  a_ch_masked: assert property (wr_i && addr_i == 4'h8 && !wdata_i[6] |=> !ch_irq_o[1])
    else $error("channel request while masked");
  a_ctrl_readback: assert property (s_wr(4'h0) ##1 s_rd(4'h0) |=>
    (rdata_o & 8'h7f) == ($past(wdata_i, 2) & 8'h7f)) else $error("control readback wrong");
endmodule

bind timer_pwm_unit timer_pwm_unit_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ch_irq_o(ch_irq_o), .ovf_irq_o(ovf_irq_o));

/* test/timer_pwm_unit_tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the timer.
// ----------------------------------------
module timer_pwm_unit_tb_top;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg xclk = 1'b0;
  reg low_freq_oscillator = 1'b0;
  reg [1:0] ext = 2'b00;
  wire [7:0] rdata_o;
  wire [1:0] pin_i, pin_o, pin_oe_o, ch_irq_o;
  wire ovf_irq_o;
  integer fails = 0, n_checks = 0, i, j, k, v, n, e, f;
  reg [7:0] rd;
  reg [15:0] c, d;
  reg [3:0] a;
  integer exp_q[$];
  timer_pwm_unit DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .crystal_derived_clock_i(xclk),
    .low_freq_oscillator_i(low_freq_oscillator), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .ch_irq_o(ch_irq_o), .ovf_irq_o(ovf_irq_o));
  pin_partner far (.tmr_out_i(pin_o), .tmr_oe_i(pin_oe_o), .ext_i(ext), .wire_o(pin_i));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // The 500 kHz source toggles on falling bus clock edges, off the rising ones.
  initial begin
    forever #1000 xclk = ~xclk;
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Reference counter written from the counting rules, one step per tick.
  function integer model_count(input integer steps, input integer top, input integer center);
    integer n, cnt, dn;
    begin
      cnt = 0;
      dn = 0;
      for (n = 0; n < steps; n = n + 1) begin
        if (center == 0) begin
          cnt = (cnt == top) ? 0 : cnt + 1;
        end else if (dn == 0) begin
          dn = (cnt == top);
          cnt = dn ? cnt - 1 : cnt + 1;
        end else begin
          dn = (cnt != 1);
          cnt = cnt - 1;
        end
      end
      model_count = cnt;
    end
  endfunction
  task wr_rd(input [3:0] ad, input [7:0] dt, output [7:0] q);
    begin
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= ad;
      wdata_i <= dt;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 q = rdata_o;
    end
  endtask
  task wr(input [3:0] ad, input [7:0] dt);
    begin
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= ad;
      wdata_i <= dt;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rdr(input [3:0] ad, output [7:0] dt);
    begin
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= ad;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 dt = rdata_o;
    end
  endtask
  task rdcnt(output [15:0] cv);
    begin
      rdr(4'h1, cv[15:8]);
      rdr(4'h2, cv[7:0]);
    end
  endtask
  task tally_and_finish;
    begin
      if (fails == 0 && n_checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  initial begin
    #400000;
    fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    v = $urandom(85);
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      rdr(i[3:0], rd);
      check(rd, 8'h00);
    end
    for (i = 0; i < 32; i = i + 1) begin
      wr_rd(4'h0, {3'b100, i[4:0]}, rd);
      check(rd, {3'b000, i[4:0]});
    end
    for (i = 0; i < 8; i = i + 1) begin
      v = $urandom;
      wr(4'h0, 8'h00);
      wr_rd(4'h1, v[7:0], rd);
      check(rd, 8'h00);
      wr(4'h0, {5'h01, i[2:0]});
      repeat (256) @(posedge mclk_i);
      rdcnt(c);
      k = model_count(257 >> i, 65535, 0) - c;
      check(k * k <= 4, 1'b1);
    end
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h18);
    repeat (1000) @(posedge mclk_i);
    rdcnt(c);
    k = 10 - c;
    check(k * k <= 1, 1'b1);
    wr(4'h0, 8'h10);
    rdcnt(c);
    repeat (50) @(posedge mclk_i);
    rdcnt(d);
    check(d, c);
    v = 20 + $urandom % 21;
    wr(4'h3, 8'h00);
    wr(4'h4, v[7:0]);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h48);
    j = 0;
    while (ovf_irq_o !== 1'b1 && j < 100) begin
      @(posedge mclk_i);
      #1 j = j + 1;
    end
    k = j - v - 1;
    check(k * k <= 1, 1'b1);
    wr(4'h0, 8'h48);
    #1 check(ovf_irq_o, 1'b1);
    rdr(4'h0, rd);
    check(rd, 8'hc8);
    wr(4'h0, 8'h48);
    #1 check(ovf_irq_o, 1'b0);
    for (k = 0; k < 2; k = k + 1) begin
      for (i = 0; i < 6; i = i + 1) begin
        a = 4'h5 + 4'h3 * k[3:0];
        e = i % 3 + 1;
        f = (i >= 3) ? e % 2 : e / 2;
        wr(a, 8'h00);
        ext[k] <= (i < 3);
        wr(a, {4'h4, e[1:0], 2'b00});
        ext[k] <= (i >= 3);
        repeat (4) @(posedge mclk_i);
        rdr(a, rd);
        check(rd, {f[0], 3'b100, e[1:0], 2'b00});
        check(ch_irq_o[k], f[0]);
      end
    end
    wr(4'h5, 8'h00);
    wr(4'hb, 8'h01);
    wr(4'h5, 8'h44);
    low_freq_oscillator <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rdr(4'h5, rd);
    check(rd, 8'hc4);
    wr(4'h5, 8'h00);
    wr(4'hb, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    for (k = 0; k < 2; k = k + 1) begin
      for (j = 0; j < 3; j = j + 1) begin
        a = 4'h5 + 4'h3 * k[3:0];
        e = 3 - j;
        wr(a, {4'h1, e[1:0], 2'b00});
        wr(a + 4'h1, 8'h00);
        wr(a + 4'h2, 8'h0a);
        wr(4'h1, 8'h00);
        repeat (30) @(posedge mclk_i);
        #1 check({pin_oe_o[k], pin_o[k]}, {1'b1, j != 1});
      end
    end
    wr(4'h4, 8'h63);
    for (j = 0; j < 2; j = j + 1) begin
      wr(4'h8, 8'h20 | (8'h04 << j));
      wr(4'h9, 8'h00);
      wr(4'ha, 8'h1e);
      repeat (200) @(posedge mclk_i);
      n = 0;
      repeat (100) begin
        @(posedge mclk_i);
        #1 n = n + pin_o[1];
      end
      k = n - (j ? 30 : 70);
      check(k * k <= 1, 1'b1);
    end
    wr(4'h5, 8'h08);
    wr(4'h0, 8'h28);
    #1 check(pin_oe_o[0], 1'b1);
    wr(4'h1, 8'h00);
    exp_q.push_back(model_count(141, 99, 1));
    repeat (140) @(posedge mclk_i);
    rdcnt(c);
    check(c, exp_q.pop_front());
    tally_and_finish;
  end
endmodule
